/* rtl/nvmp_top.sv */
/*
 Nonvolatile memory and data-space core: flash with application, table and
 boot sections, page buffers, lock bits, fuses, signature rows, EEPROM,
 SRAM and I/O storage behind a CPU port and a DMA port. Assumes all ports
 are synchronous to mclk_in and that rst_in also stands for power-on.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvmp_defines.svh"

module nvmp_top #(
	parameter int EE_BYTES = 1024,
	parameter int SRAM_BYTES = 4096,
	parameter int IO_BYTES = 64,
	parameter int FUSE_BYTES = 8,
	parameter int OP_CYCLES = 16,
	parameter logic [23:0] DEV_ID = 24'h5A3C00, // Arbitrary value
	parameter logic [47:0] SER_LOT = 48'h000000000001,
	parameter logic [7:0] SER_WAFER = 8'h01,
	parameter logic [31:0] SER_XY = 32'h00010001,
	parameter logic [7:0] CAL_OSC = 8'h80,
	parameter logic [7:0] CAL_ADC = 8'h40
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// NVM command port
	input wire logic cmd_valid_in,
	input wire logic [3:0] cmd_in,
	input wire logic cmd_from_prog_in,
	input wire logic [14:0] cmd_pc_in,
	input wire logic [14:0] cmd_addr_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic cmd_busy_out,
	output logic cpu_stall_out,
	output logic cmd_done_out,
	output logic cmd_refused_out,
	// Flash read
	input wire logic [14:0] fl_raddr_in,
	input wire logic fl_rd_prog_in,
	output logic [15:0] fl_rdata_out,
	// Signature, fuse and lock read
	input wire logic [1:0] sig_sel_in,
	input wire logic [6:0] sig_addr_in,
	output logic [7:0] sig_rdata_out,
	output logic [7:0] lock_bits_out,
	// Calibration copied at reset
	output logic [7:0] cal_osc_out,
	output logic [7:0] cal_adc_out,
	output logic cal_loaded_out,
	// CPU data port
	input wire logic c_req_in,
	input wire logic c_we_in,
	input wire logic [15:0] c_addr_in,
	input wire logic [7:0] c_wdata_in,
	output logic c_ack_out,
	output logic [7:0] c_rdata_out,
	output logic [2:0] c_rdy_out,
	// DMA data port
	input wire logic d_req_in,
	input wire logic d_we_in,
	input wire logic [15:0] d_addr_in,
	input wire logic [7:0] d_wdata_in,
	output logic d_ack_out,
	output logic [7:0] d_rdata_out,
	output logic [2:0] d_rdy_out,
	// I/O bit operations
	input wire logic [1:0] bit_op_in,
	input wire logic [4:0] bit_addr_in,
	input wire logic [2:0] bit_sel_in,
	output logic bit_test_out
);
	localparam int FL_WORDS = int'(`NVMP_BOOT_END) + 1;
	localparam int PG = `NVMP_PAGE_WORDS;
	localparam int EP = `NVMP_EE_PAGE_BYTES;
	localparam int EEA = $clog2(EE_BYTES);
	localparam int SRA = $clog2(SRAM_BYTES);
	localparam int IOA = $clog2(IO_BYTES);
	localparam int FUA = $clog2(FUSE_BYTES);
	localparam logic [14:0] BOOT_WORDS = `NVMP_BOOT_END - `NVMP_BOOT_START + 15'h1;
	localparam logic [14:0] TBL_START = `NVMP_BOOT_START - BOOT_WORDS;
	localparam logic [8:0] LAST_PG = 9'(`NVMP_BOOT_END >> `NVMP_FLASH_WORD_IN_PAGE_BITS);
	localparam logic [15:0] OP_LAST = 16'(OP_CYCLES - 1);

	// Arrays: flash, user row and EEPROM carry no reset; fuses and lock bits reset to FF
	logic [15:0] flash_mem [FL_WORDS];
	logic [15:0] usig_mem [PG];
	logic [15:0] fl_buf [PG];
	logic [7:0] ee_mem [EE_BYTES];
	logic [7:0] ee_buf [EP];
	logic [EP-1:0] ee_bv_r;
	logic [7:0] sram_mem [SRAM_BYTES];
	logic [7:0] io_mem [IO_BYTES];
	logic [7:0] fuse_r [FUSE_BYTES];
	logic [7:0] lock_r;

	nvmp_pkg::nvmp_state_t st_r, st_nxt;
	nvmp_pkg::nvmp_cmd_t cmd, op_cmd_r;
	logic [8:0] op_pg_r, er_pg_r;
	logic [15:0] cnt_r;
	logic op_prog_r, go, imm, refuse, spm_ok, commit;
	nvmp_pkg::nvmp_dset_t c_set, d_set;
	logic [1:0] c_lat, d_lat;
	logic c_acc, d_acc;

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Section of a flash word address
	function automatic nvmp_pkg::nvmp_sec_t sec_of(input logic [14:0] a);
		if (a >= `NVMP_BOOT_START)
			return nvmp_pkg::NVMP_SEC_BOOT;
		if (a >= TBL_START)
			return nvmp_pkg::NVMP_SEC_TBL;
		return nvmp_pkg::NVMP_SEC_APP;
	endfunction

	// Lock field of the section holding address a
	function automatic logic [1:0] lock_of(input logic [7:0] lk, input logic [14:0] a);
		unique case (sec_of(a))
			nvmp_pkg::NVMP_SEC_APP: return lk[1:0];
			nvmp_pkg::NVMP_SEC_TBL: return lk[3:2];
			default: return lk[5:4];
		endcase
	endfunction

	// Production row contents; never written
	function automatic logic [7:0] sig_byte(input logic [6:0] a);
		unique case (a)
			`NVMP_SIG_CAL_OSC: return CAL_OSC;
			`NVMP_SIG_CAL_ADC: return CAL_ADC;
			`NVMP_SIG_WAFER: return SER_WAFER;
			default:
			begin
				if (a >= `NVMP_SIG_LOT && a < `NVMP_SIG_LOT + 7'h6)
					return SER_LOT[8 * (a - `NVMP_SIG_LOT) +: 8];
				if (a >= `NVMP_SIG_XY && a < `NVMP_SIG_XY + 7'h4)
					return SER_XY[8 * (a - `NVMP_SIG_XY) +: 8];
				if (a >= `NVMP_SIG_DEVID && a < `NVMP_SIG_DEVID + 7'h3)
					return DEV_ID[8 * (a - `NVMP_SIG_DEVID) +: 8];
				return `NVMP_ERASED_B;
			end
		endcase
	endfunction

	// Memory set of a data-space byte address
	function automatic nvmp_pkg::nvmp_dset_t dset_of(input logic [15:0] a);
		if (a < IO_BYTES)
			return nvmp_pkg::NVMP_DS_IO;
		if (a >= `NVMP_EE_BASE && a < `NVMP_EE_BASE + 16'(EE_BYTES))
			return nvmp_pkg::NVMP_DS_EE;
		if (a >= `NVMP_SRAM_BASE && a < `NVMP_SRAM_BASE + 16'(SRAM_BYTES))
			return nvmp_pkg::NVMP_DS_SRAM;
		return nvmp_pkg::NVMP_DS_NONE;
	endfunction

	// Answer latency per set and direction
	function automatic logic [1:0] lat_of(input nvmp_pkg::nvmp_dset_t s, input logic we);
		if (!we && s == nvmp_pkg::NVMP_DS_SRAM)
			return `NVMP_LAT_SRAM_RD;
		if (!we && s == nvmp_pkg::NVMP_DS_EE)
			return `NVMP_LAT_EE_RD;
		return `NVMP_LAT_ONE;
	endfunction

	// Read data of a set at an address; unmapped reads as zero
	function automatic logic [7:0] rd_of(input nvmp_pkg::nvmp_dset_t s, input logic [15:0] a);
		unique case (s)
			nvmp_pkg::NVMP_DS_IO: return io_mem[a[IOA-1:0]];
			nvmp_pkg::NVMP_DS_EE: return ee_mem[a[EEA-1:0]];
			nvmp_pkg::NVMP_DS_SRAM: return sram_mem[a[SRA-1:0]];
			default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Command decode; one command at a time, others refused while busy
	always_comb
	begin
		cmd = nvmp_pkg::nvmp_cmd_t'(cmd_in);
		spm_ok = cmd_from_prog_in || sec_of(cmd_pc_in) == nvmp_pkg::NVMP_SEC_BOOT;
		go = 1'b0;
		imm = 1'b0;
		refuse = 1'b0;
		if (cmd_valid_in && st_r != nvmp_pkg::NVMP_ST_IDLE)
			refuse = 1'b1;
		else if (cmd_valid_in)
		begin
			unique case (cmd)
				nvmp_pkg::NVMP_CMD_NOP: imm = 1'b1;
				nvmp_pkg::NVMP_CMD_FL_LOAD: {imm, refuse} = {spm_ok, !spm_ok};
				nvmp_pkg::NVMP_CMD_FL_ERASE, nvmp_pkg::NVMP_CMD_FL_WRITE,
				nvmp_pkg::NVMP_CMD_FL_ERWR:
				begin
					go = spm_ok && lock_of(lock_r, cmd_addr_in) == `NVMP_LOCK_NONE;
					refuse = !go;
				end
				nvmp_pkg::NVMP_CMD_USIG_ERASE, nvmp_pkg::NVMP_CMD_USIG_WRITE:
					{go, refuse} = {spm_ok, !spm_ok};
				nvmp_pkg::NVMP_CMD_LOCK_WRITE: imm = 1'b1;
				nvmp_pkg::NVMP_CMD_FUSE_WRITE, nvmp_pkg::NVMP_CMD_CHIP_ERASE:
					{go, imm, refuse} = {cmd == nvmp_pkg::NVMP_CMD_CHIP_ERASE && cmd_from_prog_in,
						cmd == nvmp_pkg::NVMP_CMD_FUSE_WRITE && cmd_from_prog_in, !cmd_from_prog_in};
				nvmp_pkg::NVMP_CMD_EE_ERASE, nvmp_pkg::NVMP_CMD_EE_WRITE,
				nvmp_pkg::NVMP_CMD_EE_ERWR: go = 1'b1;
				default: refuse = 1'b1;
			endcase
		end
	end

	// Next state of the operation sequencer
	always_comb
	begin
		st_nxt = st_r;
		commit = st_r == nvmp_pkg::NVMP_ST_RUN && cnt_r == 16'h0000;
		unique case (st_r)
			nvmp_pkg::NVMP_ST_IDLE:
				if (go)
					st_nxt = cmd == nvmp_pkg::NVMP_CMD_CHIP_ERASE ? nvmp_pkg::NVMP_ST_CERASE : nvmp_pkg::NVMP_ST_RUN;
			nvmp_pkg::NVMP_ST_RUN:
				if (commit)
					st_nxt = nvmp_pkg::NVMP_ST_IDLE;
			nvmp_pkg::NVMP_ST_CERASE:
				if (er_pg_r == LAST_PG)
					st_nxt = nvmp_pkg::NVMP_ST_CLOCK;
			nvmp_pkg::NVMP_ST_CLOCK: st_nxt = nvmp_pkg::NVMP_ST_IDLE;
		endcase
	end

	// Sequencer, op latch and countdown
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r <= nvmp_pkg::NVMP_ST_IDLE;
			op_cmd_r <= nvmp_pkg::NVMP_CMD_NOP;
			op_pg_r <= 9'h000;
			op_prog_r <= 1'b0;
			cnt_r <= 16'h0000;
			er_pg_r <= 9'h000;
		end
		else
		begin
			st_r <= st_nxt;
			if (go)
			begin
				op_cmd_r <= cmd;
				op_pg_r <= cmd_addr_in[14:`NVMP_FLASH_WORD_IN_PAGE_BITS];
				op_prog_r <= cmd_from_prog_in;
				cnt_r <= OP_LAST;
				er_pg_r <= 9'h000;
			end
			else
			begin
				if (cnt_r != 16'h0000)
					cnt_r <= cnt_r - 16'h0001;
				if (st_r == nvmp_pkg::NVMP_ST_CERASE)
					er_pg_r <= er_pg_r + 9'h001;
			end
		end
	end

	// Status outputs; CPU held while its own operation runs
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cmd_busy_out <= 1'b0;
			cpu_stall_out <= 1'b0;
			cmd_done_out <= 1'b0;
			cmd_refused_out <= 1'b0;
		end
		else
		begin
			cmd_busy_out <= st_nxt != nvmp_pkg::NVMP_ST_IDLE;
			cpu_stall_out <= st_nxt != nvmp_pkg::NVMP_ST_IDLE && (go ? !cmd_from_prog_in : !op_prog_r);
			cmd_done_out <= imm || commit || st_r == nvmp_pkg::NVMP_ST_CLOCK;
			cmd_refused_out <= refuse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash page buffer; emptied to erased after each page commit
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			fl_buf <= '{default: `NVMP_ERASED_W};
		else if (commit)
			fl_buf <= '{default: `NVMP_ERASED_W};
		else if (imm && cmd == nvmp_pkg::NVMP_CMD_FL_LOAD)
			fl_buf[cmd_addr_in[`NVMP_FLASH_WORD_IN_PAGE_BITS-1:0]] <= cmd_wdata_in;
	end

	// Flash array: page commits and page-by-page chip erase
	always_ff @(posedge mclk_in)
	begin
		for (int i = 0; i < PG; i++)
		begin
			if (commit && op_cmd_r == nvmp_pkg::NVMP_CMD_FL_ERASE)
				flash_mem[{op_pg_r, 6'(i)}] <= `NVMP_ERASED_W;
			if (commit && op_cmd_r == nvmp_pkg::NVMP_CMD_FL_WRITE)
				flash_mem[{op_pg_r, 6'(i)}] <= flash_mem[{op_pg_r, 6'(i)}] & fl_buf[i]; // Only clears bits
			if (commit && op_cmd_r == nvmp_pkg::NVMP_CMD_FL_ERWR)
				flash_mem[{op_pg_r, 6'(i)}] <= fl_buf[i];
			if (st_r == nvmp_pkg::NVMP_ST_CERASE)
				flash_mem[{er_pg_r, 6'(i)}] <= `NVMP_ERASED_W;
		end
	end

	// User row: only its own commands touch it, never chip erase
	always_ff @(posedge mclk_in)
	begin
		for (int i = 0; i < PG; i++)
		begin
			if (commit && op_cmd_r == nvmp_pkg::NVMP_CMD_USIG_ERASE)
				usig_mem[i] <= `NVMP_ERASED_W;
			if (commit && op_cmd_r == nvmp_pkg::NVMP_CMD_USIG_WRITE)
				usig_mem[i] <= usig_mem[i] & fl_buf[i];
		end
	end

	// Lock bits: AND only tightens; cleared after the erase walk
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			lock_r <= `NVMP_LOCK_RST;
		else if (st_r == nvmp_pkg::NVMP_ST_CLOCK)
			lock_r <= `NVMP_LOCK_RST;
		else if (imm && cmd == nvmp_pkg::NVMP_CMD_LOCK_WRITE)
			lock_r <= lock_r & cmd_wdata_in[7:0];
	end

	// Fuses: programmer writes only
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			fuse_r <= '{default: `NVMP_FUSE_RST};
		else if (imm && cmd == nvmp_pkg::NVMP_CMD_FUSE_WRITE)
			fuse_r[cmd_addr_in[FUA-1:0]] <= cmd_wdata_in[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Read ports; programmer reads of a read-locked section see erased data
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			fl_rdata_out <= `NVMP_ERASED_W;
			sig_rdata_out <= `NVMP_ERASED_B;
			lock_bits_out <= `NVMP_LOCK_RST;
		end
		else
		begin
			fl_rdata_out <= fl_rd_prog_in && (lock_of(lock_r, fl_raddr_in) & 2'h1) == 2'h0 ? `NVMP_ERASED_W
				: flash_mem[fl_raddr_in];
			unique case (sig_sel_in)
				2'h0: sig_rdata_out <= sig_byte(sig_addr_in);
				2'h1: sig_rdata_out <= usig_mem[sig_addr_in[6:1]][8 * sig_addr_in[0] +: 8];
				2'h2: sig_rdata_out <= fuse_r[sig_addr_in[FUA-1:0]];
				default: sig_rdata_out <= lock_r;
			endcase
			lock_bits_out <= lock_r;
		end
	end

	// Calibration copy on the first edge after reset release
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cal_loaded_out <= 1'b0;
			cal_osc_out <= 8'h00;
			cal_adc_out <= 8'h00;
		end
		else if (!cal_loaded_out)
		begin
			cal_loaded_out <= 1'b1;
			cal_osc_out <= sig_byte(`NVMP_SIG_CAL_OSC);
			cal_adc_out <= sig_byte(`NVMP_SIG_CAL_ADC);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data-space arbitration: CPU wins a set both masters want
	always_comb
	begin
		c_set = dset_of(c_addr_in);
		d_set = dset_of(d_addr_in);
		c_lat = lat_of(c_set, c_we_in);
		d_lat = lat_of(d_set, d_we_in);
		c_acc = c_req_in && c_rdy_out[c_lat - 2'h1];
		d_acc = d_req_in && d_rdy_out[d_lat - 2'h1] && !(c_acc && c_set == d_set);
	end

	// SRAM writes, at most one master per cycle
	always_ff @(posedge mclk_in)
	begin
		if (c_acc && c_we_in && c_set == nvmp_pkg::NVMP_DS_SRAM)
			sram_mem[c_addr_in[SRA-1:0]] <= c_wdata_in;
		if (d_acc && d_we_in && d_set == nvmp_pkg::NVMP_DS_SRAM)
			sram_mem[d_addr_in[SRA-1:0]] <= d_wdata_in;
	end

	// I/O storage; low four bytes are general purpose
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			io_mem <= '{default: 8'h00};
		else
		begin
			if (c_acc && c_we_in && c_set == nvmp_pkg::NVMP_DS_IO)
				io_mem[c_addr_in[IOA-1:0]] <= c_wdata_in;
			if (d_acc && d_we_in && d_set == nvmp_pkg::NVMP_DS_IO)
				io_mem[d_addr_in[IOA-1:0]] <= d_wdata_in;
			if (nvmp_pkg::nvmp_bitop_t'(bit_op_in) == nvmp_pkg::NVMP_BIT_SET)
				io_mem[bit_addr_in][bit_sel_in] <= 1'b1;
			if (nvmp_pkg::nvmp_bitop_t'(bit_op_in) == nvmp_pkg::NVMP_BIT_CLR)
				io_mem[bit_addr_in][bit_sel_in] <= 1'b0;
		end
	end

	// Bit test result for skip instructions
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			bit_test_out <= 1'b0;
		else if (nvmp_pkg::nvmp_bitop_t'(bit_op_in) == nvmp_pkg::NVMP_BIT_TEST)
			bit_test_out <= io_mem[bit_addr_in][bit_sel_in];
	end

	// EEPROM page buffer: stores load it in one cycle
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			ee_bv_r <= '0;
		else
		begin
			if (commit && op_cmd_r != nvmp_pkg::NVMP_CMD_EE_ERASE)
				ee_bv_r <= '0;
			if (c_acc && c_we_in && c_set == nvmp_pkg::NVMP_DS_EE)
				ee_bv_r[c_addr_in[`NVMP_EBYTE_BITS-1:0]] <= 1'b1;
			if (d_acc && d_we_in && d_set == nvmp_pkg::NVMP_DS_EE)
				ee_bv_r[d_addr_in[`NVMP_EBYTE_BITS-1:0]] <= 1'b1;
		end
	end

	// Buffer data beside its valid flags
	always_ff @(posedge mclk_in)
	begin
		if (c_acc && c_we_in && c_set == nvmp_pkg::NVMP_DS_EE)
			ee_buf[c_addr_in[`NVMP_EBYTE_BITS-1:0]] <= c_wdata_in;
		if (d_acc && d_we_in && d_set == nvmp_pkg::NVMP_DS_EE)
			ee_buf[d_addr_in[`NVMP_EBYTE_BITS-1:0]] <= d_wdata_in;
	end

	// EEPROM commit: erase selects loaded bytes, so one byte or a whole page
	always_ff @(posedge mclk_in)
	begin
		for (int i = 0; i < EP; i++)
		begin
			if (commit && ee_bv_r[i] && op_cmd_r == nvmp_pkg::NVMP_CMD_EE_ERASE)
				ee_mem[EEA'({op_pg_r, 6'h00} >> 1) | EEA'(i)] <= `NVMP_ERASED_B;
			if (commit && ee_bv_r[i] && op_cmd_r == nvmp_pkg::NVMP_CMD_EE_WRITE)
				ee_mem[EEA'({op_pg_r, 6'h00} >> 1) | EEA'(i)] <=
					ee_mem[EEA'({op_pg_r, 6'h00} >> 1) | EEA'(i)] & ee_buf[i];
			if (commit && ee_bv_r[i] && op_cmd_r == nvmp_pkg::NVMP_CMD_EE_ERWR)
				ee_mem[EEA'({op_pg_r, 6'h00} >> 1) | EEA'(i)] <= ee_buf[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One latency pipe per master keeps their buses independent
	nvmp_lat_pipe u_cpipe (
		.mclk_in(mclk_in), .rst_in(rst_in), .acc_in(c_acc), .lat_in(c_lat),
		.data_in(rd_of(c_set, c_addr_in)), .ee_rd_in(!c_we_in && c_set == nvmp_pkg::NVMP_DS_EE),
		.ack_out(c_ack_out), .rdata_out(c_rdata_out), .rdy_out(c_rdy_out)
	);
	nvmp_lat_pipe u_dpipe (
		.mclk_in(mclk_in), .rst_in(rst_in), .acc_in(d_acc), .lat_in(d_lat),
		.data_in(rd_of(d_set, d_addr_in)), .ee_rd_in(!d_we_in && d_set == nvmp_pkg::NVMP_DS_EE),
		.ack_out(d_ack_out), .rdata_out(d_rdata_out), .rdy_out(d_rdy_out)
	);
endmodule
`default_nettype wire

/* include/nvmp_defines.svh */
/*
 Constants for the nonvolatile memory and data-space block: flash section
 map, page geometry, data-space bases, access latencies, reset values and
 signature row layout. Assumes inclusion by bare name from the rtl files.
*/
`ifndef NVMP_DEFINES_SVH
`define NVMP_DEFINES_SVH
// Flash word map, largest variant
`define NVMP_BOOT_START 15'h4000
`define NVMP_BOOT_END 15'h47FF
`define NVMP_PAGE_WORDS 64
`define NVMP_FLASH_WORD_IN_PAGE_BITS 6
// Data space
`define NVMP_EE_BASE 16'h1000
`define NVMP_SRAM_BASE 16'h2000
`define NVMP_EE_PAGE_BYTES 32
`define NVMP_EBYTE_BITS 5
`define NVMP_GPIO_REGS 4
// Access latencies in cycles
`define NVMP_LAT_ONE 2'h1
`define NVMP_LAT_SRAM_RD 2'h2
`define NVMP_LAT_EE_RD 2'h3
// Reset and erased values
`define NVMP_LOCK_NONE 2'h3
`define NVMP_LOCK_RST 8'hFF
`define NVMP_FUSE_RST 8'hFF
`define NVMP_ERASED_W 16'hFFFF
`define NVMP_ERASED_B 8'hFF
// Production signature row byte offsets
`define NVMP_SIG_CAL_OSC 7'h00
`define NVMP_SIG_CAL_ADC 7'h01
`define NVMP_SIG_LOT 7'h08
`define NVMP_SIG_WAFER 7'h10
`define NVMP_SIG_XY 7'h12
`define NVMP_SIG_DEVID 7'h20
`endif

/* include/nvmp_pkg.sv */
/*
 Types for the nonvolatile memory block: command codes, sections, data
 sets, bit operations and controller states. Stands alone.
*/
package nvmp_pkg;
	typedef enum logic [3:0] {
		NVMP_CMD_NOP = 4'h0, NVMP_CMD_FL_LOAD = 4'h1, NVMP_CMD_FL_ERASE = 4'h2,
		NVMP_CMD_FL_WRITE = 4'h3, NVMP_CMD_FL_ERWR = 4'h4, NVMP_CMD_USIG_ERASE = 4'h5,
		NVMP_CMD_USIG_WRITE = 4'h6, NVMP_CMD_LOCK_WRITE = 4'h7, NVMP_CMD_FUSE_WRITE = 4'h8,
		NVMP_CMD_CHIP_ERASE = 4'h9, NVMP_CMD_EE_ERASE = 4'hA, NVMP_CMD_EE_WRITE = 4'hB,
		NVMP_CMD_EE_ERWR = 4'hC
	} nvmp_cmd_t;
	typedef enum logic [1:0] {NVMP_SEC_APP, NVMP_SEC_TBL, NVMP_SEC_BOOT} nvmp_sec_t;
	typedef enum logic [1:0] {NVMP_DS_IO, NVMP_DS_EE, NVMP_DS_SRAM, NVMP_DS_NONE} nvmp_dset_t;
	typedef enum logic [1:0] {NVMP_BIT_NONE, NVMP_BIT_SET, NVMP_BIT_CLR, NVMP_BIT_TEST} nvmp_bitop_t;
	typedef enum {NVMP_ST_IDLE, NVMP_ST_RUN, NVMP_ST_CERASE, NVMP_ST_CLOCK} nvmp_state_t;
endpackage

/* rtl/nvmp_lat_pipe.sv */
/*
 Latency pipe for one data-space master: delays read data by 1, 2 or 3
 cycles and predicts which latencies can be taken next cycle. Assumes the
 caller only accepts a request whose latency the ready flags allow.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvmp_defines.svh"

module nvmp_lat_pipe (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Accepted request
	input wire logic acc_in,
	input wire logic [1:0] lat_in,
	input wire logic [7:0] data_in,
	input wire logic ee_rd_in,
	// Answer and readiness
	output logic ack_out,
	output logic [7:0] rdata_out,
	output logic [2:0] rdy_out
);
	logic [2:0] v_r, v_nxt;
	logic [7:0] d_r [3];
	logic [7:0] d_nxt [3];

	////////////////////////////////////////////////////////////////////////
	// Shift one stage per cycle; a new entry lands lat_in-1 stages out
	always_comb
	begin
		v_nxt = {1'b0, v_r[2:1]};
		d_nxt[0] = d_r[1];
		d_nxt[1] = d_r[2];
		d_nxt[2] = 8'h00;
		if (acc_in)
		begin
			v_nxt[lat_in - 2'h1] = 1'b1;
			d_nxt[lat_in - 2'h1] = data_in;
		end
	end

	// Pipe stages; stage 0 is the answer
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			v_r <= 3'h0;
			d_r <= '{8'h00, 8'h00, 8'h00};
		end
		else
		begin
			v_r <= v_nxt;
			d_r <= d_nxt;
		end
	end

	// Ready for next cycle: latencies 1 and 2 when no entry in flight collides; latency 3 unless an EEPROM read was just accepted
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			rdy_out <= 3'h7;
		else
			rdy_out <= {!(acc_in && ee_rd_in), !v_nxt[2], !v_nxt[1]};
	end

	assign ack_out = v_r[0];
	assign rdata_out = d_r[0];
endmodule
`default_nettype wire

/* dv/nvmp_chk.sv */
/* Port assertions for nvmp_top.
 Bound into every nvmp_top; one clock, async reset. */
`timescale 1ns/1ps
`default_nettype none
module nvmp_chk (
	// Clock, reset, command port
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic [3:0] cmd_in,
	input wire logic cmd_from_prog_in,
	input wire logic cmd_busy_out,
	input wire logic cpu_stall_out,
	input wire logic cmd_done_out,
	input wire logic cmd_refused_out,
	input wire logic [7:0] lock_bits_out,
	// CPU data port
	input wire logic c_req_in,
	input wire logic c_we_in,
	input wire logic [15:0] c_addr_in,
	input wire logic c_ack_out,
	input wire logic [2:0] c_rdy_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_stall_busy: assert property (cpu_stall_out |-> cmd_busy_out)
		else $error("stall without busy");
	a_fuse_cpu: assert property (cmd_valid_in && !cmd_busy_out && !cmd_from_prog_in && cmd_in == 4'h8 |=> cmd_refused_out)
		else $error("cpu fuse write taken");
	a_chip_cpu: assert property (cmd_valid_in && !cmd_busy_out && !cmd_from_prog_in && cmd_in == 4'h9 |=> cmd_refused_out)
		else $error("cpu chip erase taken");
	// Locks relax only at the end of an operation
	a_lock_tight: assert property ((lock_bits_out & ~$past(lock_bits_out)) != 8'h00 |-> $past(cmd_busy_out, 2))
		else $error("lock relaxed");
	a_io_lat: assert property (c_req_in && c_rdy_out[0] && c_addr_in < 16'h1000 |=> c_ack_out)
		else $error("io ack late");
	a_sram_lat: assert property (c_req_in && c_rdy_out[1] && !c_we_in && c_addr_in[15:12] == 4'h2 |-> ##2 c_ack_out)
		else $error("sram read ack late");
	a_ee_lat: assert property (c_req_in && c_rdy_out[2] && !c_we_in && c_addr_in[15:10] == 6'h04 |-> ##3 c_ack_out)
		else $error("eeprom read ack late");
	a_busy_done: assert property ($fell(cmd_busy_out) |-> cmd_done_out)
		else $error("busy ended without done");
endmodule
bind nvmp_top nvmp_chk u_chk (.*);
`default_nettype wire

/* dv/nvmp_dma_model.sv */
/* DMA master model reading SRAM in bursts.
 Assumes the core's DMA port timing of nvmp_top. */
`timescale 1ns/1ps
`default_nettype none
module nvmp_dma_model (
	// Bench control
	input wire logic mclk_in,
	input wire logic go_in,
	input wire logic [15:0] addr_in,
	// Core DMA port
	input wire logic [2:0] d_rdy_in,
	input wire logic d_ack_in,
	input wire logic [7:0] d_rdata_in,
	output logic d_req_out,
	output logic [15:0] d_addr_out,
	// Results
	output logic [7:0] last_out,
	output logic [7:0] acks_out
);
	initial
	begin
		d_req_out = 1'b0;
		acks_out = 8'h00;
	end
	// One read per edge while the SRAM slot is free
	always @(negedge mclk_in)
		d_req_out <= go_in && d_rdy_in[1];
	// Idle address inverted so stale values never look valid
	assign d_addr_out = d_req_out ? addr_in : ~addr_in;
	// Keep last datum and count answers
	always @(posedge mclk_in)
		if (d_ack_in)
		begin
			last_out <= d_rdata_in;
			acks_out <= acks_out + 8'h01;
		end
endmodule
`default_nettype wire

/* dv/tb.sv */
/* Directed bench for nvmp_top with a DMA model.
 Inputs change at the falling edge; OP_CYCLES set to 2. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	logic mclk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, cmd_from_prog_in = 1'b0, fl_rd_prog_in = 1'b0;
	logic c_req_in = 1'b0, c_we_in = 1'b0, d_we_in = 1'b0, d_req_in, go = 1'b0;
	logic [3:0] cmd_in = 4'h0;
	logic [14:0] cmd_pc_in = 15'h0000, cmd_addr_in = 15'h0000, fl_raddr_in = 15'h0000;
	logic [15:0] cmd_wdata_in = 16'h0000, c_addr_in = 16'h0000, d_addr_in, fl_rdata_out;
	logic [1:0] sig_sel_in = 2'h0, bit_op_in = 2'h0, r;
	logic [6:0] sig_addr_in = 7'h00;
	logic [4:0] bit_addr_in = 5'h00;
	logic [2:0] bit_sel_in = 3'h0, c_rdy_out, d_rdy_out;
	logic [7:0] c_wdata_in = 8'h00, d_wdata_in = 8'h00, rd, m_last, m_acks, sig_rdata_out, lock_bits_out;
	logic [7:0] cal_osc_out, cal_adc_out, c_rdata_out, d_rdata_out;
	logic cmd_busy_out, cpu_stall_out, cmd_done_out, cmd_refused_out, cal_loaded_out, c_ack_out, d_ack_out, bit_test_out;
	int n_errors = 0, tests_run = 0, i;
	nvmp_top #(.OP_CYCLES(2)) DUT (.*);
	nvmp_dma_model u_dma (.mclk_in(mclk_in), .go_in(go), .addr_in(16'h2000), .d_rdy_in(d_rdy_out),
		.d_ack_in(d_ack_out), .d_rdata_in(d_rdata_out), .d_req_out(d_req_in), .d_addr_out(d_addr_in),
		.last_out(m_last), .acks_out(m_acks));
	initial
		forever #2 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task tmo;
		n_errors++;
		summarize;
	endtask
	// One command, then wait for done or refusal
	task cmd(input logic [3:0] c, input logic p, input logic [14:0] pc, input logic [14:0] a, input logic [15:0] w);
		@(negedge mclk_in);
		{cmd_valid_in, cmd_in, cmd_from_prog_in, cmd_pc_in, cmd_addr_in, cmd_wdata_in} = {1'b1, c, p, pc, a, w};
		@(negedge mclk_in);
		cmd_valid_in = 1'b0;
		for (i = 0; i < 400 && !(cmd_done_out || cmd_refused_out); i++)
			@(negedge mclk_in);
		if (i == 400)
			tmo;
		r = {cmd_refused_out, cmd_done_out};
	endtask
	// CPU data access; request raised only when its latency slot is free
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		int k;
		k = (a < 16'h1000 || w) ? 0 : (a < 16'h2000 ? 2 : 1);
		@(negedge mclk_in);
		for (i = 0; i < 20 && c_rdy_out[k] !== 1'b1; i++)
			@(negedge mclk_in);
		if (i == 20)
			tmo;
		{c_req_in, c_we_in, c_addr_in, c_wdata_in} = {1'b1, w, a, d};
		@(negedge mclk_in);
		c_req_in = 1'b0;
		for (i = 0; i < 20 && c_ack_out !== 1'b1; i++)
			@(negedge mclk_in);
		if (i == 20)
			tmo;
		rd = c_rdata_out;
	endtask
	// Flash and signature read, answer one edge later
	task pk(input logic [14:0] fa, input logic [1:0] s, input logic [6:0] sa);
		@(negedge mclk_in);
		{fl_raddr_in, sig_sel_in, sig_addr_in} = {fa, s, sa};
		@(negedge mclk_in);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(negedge mclk_in);
		rst_in = 1'b0;
		@(negedge mclk_in);
		`CHK({cal_loaded_out, cal_osc_out, cal_adc_out}, 17'h18040)
		`CHK(lock_bits_out, 8'hFF)
		pk(15'h0000, 2'h2, 7'h00);
		`CHK(sig_rdata_out, 8'hFF)
		pk(15'h0000, 2'h0, 7'h10);
		`CHK(sig_rdata_out, 8'h01)
		cmd(4'h8, 1'b0, 15'h4000, 15'h0000, 16'h0000);
		`CHK(r, 2'b10)
		cmd(4'h9, 1'b0, 15'h4000, 15'h0000, 16'h0000);
		`CHK(r, 2'b10)
		cmd(4'h1, 1'b0, 15'h4000, 15'h3805, 16'hA5C3);
		cmd(4'h4, 1'b0, 15'h0100, 15'h3800, 16'h0000);
		`CHK(r, 2'b10)
		cmd(4'h4, 1'b0, 15'h47FF, 15'h3800, 16'h0000);
		`CHK(r, 2'b01)
		pk(15'h3805, 2'h0, 7'h00);
		`CHK(fl_rdata_out, 16'hA5C3)
		pk(15'h3806, 2'h0, 7'h00);
		`CHK(fl_rdata_out, 16'hFFFF)
		cmd(4'h7, 1'b1, 15'h0000, 15'h0000, 16'h00F3);
		cmd(4'h7, 1'b0, 15'h4000, 15'h0000, 16'h00FF);
		`CHK(lock_bits_out, 8'hF3)
		cmd(4'h2, 1'b0, 15'h4000, 15'h3800, 16'h0000);
		`CHK(r, 2'b10)
		pk(15'h3805, 2'h0, 7'h00);
		`CHK(fl_rdata_out, 16'hA5C3)
		cmd(4'h2, 1'b0, 15'h4000, 15'h4040, 16'h0000);
		`CHK(r, 2'b01)
		fl_rd_prog_in = 1'b1;
		pk(15'h3805, 2'h0, 7'h00);
		`CHK(fl_rdata_out, 16'hFFFF)
		fl_rd_prog_in = 1'b0;
		pk(15'h0000, 2'h3, 7'h00);
		`CHK(sig_rdata_out, 8'hF3)
		cmd(4'h5, 1'b1, 15'h0000, 15'h0000, 16'h0000);
		cmd(4'h1, 1'b1, 15'h0000, 15'h0000, 16'h1234);
		cmd(4'h6, 1'b1, 15'h0000, 15'h0000, 16'h0000);
		cmd(4'h9, 1'b1, 15'h0000, 15'h0000, 16'h0000);
		pk(15'h3805, 2'h0, 7'h00);
		`CHK({lock_bits_out, fl_rdata_out}, 24'hFFFFFF)
		pk(15'h0000, 2'h1, 7'h01);
		`CHK(sig_rdata_out, 8'h12)
		acc(1'b1, 16'h0001, 8'h5A);
		acc(0, 16'h0001, 8'h00);
		`CHK(rd, 8'h5A)
		acc(1'b1, 16'h2000, 8'h3C);
		acc(0, 16'h2000, 8'h00);
		`CHK(rd, 8'h3C)
		acc(1'b1, 16'h1003, 8'h77);
		cmd(4'hC, 1'b0, 15'h4000, 15'h0000, 16'h0000);
		acc(0, 16'h1003, 8'h00);
		`CHK(rd, 8'h77)
		acc(1'b1, 16'h0002, 8'h00);
		@(negedge mclk_in);
		{bit_op_in, bit_addr_in, bit_sel_in} = {2'h1, 5'h02, 3'h3};
		@(negedge mclk_in);
		bit_op_in = 2'h0;
		acc(0, 16'h0002, 8'h00);
		`CHK(rd, 8'h08)
		@(negedge mclk_in);
		bit_op_in = 2'h3;
		@(negedge mclk_in);
		`CHK(bit_test_out, 1'b1)
		bit_op_in = 2'h2;
		@(negedge mclk_in);
		bit_op_in = 2'h3;
		@(negedge mclk_in);
		`CHK(bit_test_out, 1'b0)
		bit_op_in = 2'h0;
		go <= 1'b1;
		acc(0, 16'h0001, 8'h00);
		go <= 1'b0;
		repeat (4) @(negedge mclk_in);
		`CHK({rd, m_last, m_acks > 8'h01}, 17'hB479)
		summarize;
	end
endmodule
`default_nettype wire
